// [csr_core_regs.sv]
/*
  Core special registers: pointers and indirect ports, accumulator,
  program counter low byte, table pointers and result, status flags.
  Assumes an asynchronous-read data memory on ram_addr_ff and a program
  memory returning rom_data in the cycle that rom_rd_ff is high.
*/
`timescale 1ns/100ps
module csr_core_regs (
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  input  wire logic                       op_valid,
  input  wire csr_pkg::csr_op_t           op_code,
  input  wire logic [7:0]                 op_addr,
  input  wire logic                       op_to_acc,
  input  wire logic [1:0]                 ptr_b_bank,
  input  wire logic                       pc_step,
  input  wire logic                       wdt_timeout,
  input  wire logic [7:0]                 ram_rdata,
  input  wire logic [15:0]                rom_data,
  output logic                            busy_ff,
  output logic [csr_pkg::DM_W-1:0]        ram_addr_ff,
  output logic                            ram_rd_ff,
  output logic                            ram_wr_ff,
  output logic [7:0]                      ram_wdata_ff,
  output logic [csr_pkg::PC_W-1:0]        rom_addr_ff,
  output logic                            rom_rd_ff,
  output logic [csr_pkg::PC_W-1:0]        pc_ff,
  output logic                            jump_ff,
  output logic [7:0]                      working_reg_ff,
  output logic [7:0]                      status_ff
);
  csr_pkg::csr_state_t state_ff, nxt_state;
  csr_pkg::csr_op_t    op_ff, nxt_op;
  logic                to_acc_ff, nxt_to_acc;
  logic                loc_ff, nxt_loc;
  logic                null_ff, nxt_null;
  logic [csr_pkg::DM_W-1:0] nxt_ram_addr;
  logic [csr_pkg::PC_W-1:0] nxt_rom_addr, nxt_pc;
  logic                nxt_ram_rd, nxt_rom_rd, nxt_busy, nxt_jump;
  logic                nxt_ram_wr;
  logic [7:0]          nxt_ram_wdata;
  logic [7:0]          pointer_a_ff, nxt_pointer_a;
  logic [7:0]          pointer_b_ff, nxt_pointer_b;
  logic [7:0]          tblp_ff, nxt_tblp;
  logic [7:0]          tbhp_ff, nxt_tbhp;
  logic [7:0]          lookup_result_high_ff, nxt_lookup_result_high;
  logic [7:0]          nxt_acc, nxt_status;

  logic [csr_pkg::DM_W-1:0] res_addr;
  logic                res_loc, res_null, accept, wr_go, wr_pcl;
  logic [7:0]          sfr_rd, opnd, wr_data, alu_res;
  logic                alu_c, alu_ac, alu_ov, upd_c, upd_acov, upd_z;

  assign accept = op_valid && (state_ff == csr_pkg::S_IDLE);

  csr_addr_res u_res (
    .op_addr    (op_addr),
    .ptr_a      (pointer_a_ff),
    .ptr_b      (pointer_b_ff),
    .ptr_b_bank (ptr_b_bank),
    .eff_addr   (res_addr),
    .is_local   (res_loc),
    .is_null    (res_null)
  );

  csr_alu u_alu (
    .op       (op_ff),
    .acc      (working_reg_ff),
    .opnd     (opnd),
    .c_in     (status_ff[csr_pkg::ST_C]),
    .res      (alu_res),
    .c_out    (alu_c),
    .ac_out   (alu_ac),
    .ov_out   (alu_ov),
    .upd_c    (upd_c),
    .upd_acov (upd_acov),
    .upd_z    (upd_z)
  );

  // local register read mux
  always_comb begin
    unique case (ram_addr_ff[7:0])
      csr_pkg::A_PTR_A: sfr_rd = pointer_a_ff;
      csr_pkg::A_PTR_B: sfr_rd = pointer_b_ff;
      csr_pkg::A_ACC:   sfr_rd = working_reg_ff;
      csr_pkg::A_PCL:   sfr_rd = pc_ff[7:0];
      csr_pkg::A_TBLP:  sfr_rd = tblp_ff;
      csr_pkg::A_LOOKUP_RESULT_HIGH:  sfr_rd = lookup_result_high_ff;
      csr_pkg::A_TBHP:  sfr_rd = tbhp_ff;
      csr_pkg::A_STAT:  sfr_rd = status_ff;
      default:          sfr_rd = csr_pkg::NULL_BYTE;
    endcase
    opnd = null_ff ? csr_pkg::NULL_BYTE :
           (loc_ff ? sfr_rd : ram_rdata);
  end

  // sequencing and bus strobes
  always_comb begin
    nxt_state    = state_ff;
    nxt_op       = op_ff;
    nxt_to_acc   = to_acc_ff;
    nxt_loc      = loc_ff;
    nxt_null     = null_ff;
    nxt_ram_addr = ram_addr_ff;
    nxt_ram_rd   = 1'b0;
    nxt_rom_addr = rom_addr_ff;
    nxt_rom_rd   = 1'b0;
    nxt_jump     = 1'b0;
    unique case (state_ff)
      csr_pkg::S_IDLE: begin
        if (accept) begin
          nxt_op       = op_code;
          nxt_to_acc   = op_to_acc;
          nxt_loc      = res_loc;
          nxt_null     = res_null;
          nxt_ram_addr = res_addr;
          if (op_code == csr_pkg::OP_TABRD) begin
            nxt_rom_addr = csr_pkg::PC_W'({tbhp_ff, tblp_ff});
            nxt_rom_rd   = 1'b1;
            nxt_state    = csr_pkg::S_TABLE;
          end else if (op_code == csr_pkg::OP_LOAD ||
                       op_code == csr_pkg::OP_STORE ||
                       csr_pkg::is_alu(op_code)) begin
            nxt_ram_rd = !res_loc && (op_code != csr_pkg::OP_STORE);
            nxt_state  = csr_pkg::S_EXEC;
          end
        end
      end
      csr_pkg::S_EXEC, csr_pkg::S_TABLE: begin
        nxt_jump  = wr_pcl;
        nxt_state = wr_pcl ? csr_pkg::S_DUMMY : csr_pkg::S_IDLE;
      end
      csr_pkg::S_DUMMY: nxt_state = csr_pkg::S_IDLE;
    endcase
    nxt_busy = (nxt_state != csr_pkg::S_IDLE);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff    <= csr_pkg::S_IDLE;
      op_ff       <= csr_pkg::OP_NOP;
      to_acc_ff   <= 1'b0;
      loc_ff      <= 1'b0;
      null_ff     <= 1'b0;
      ram_addr_ff <= '0;
      ram_rd_ff   <= 1'b0;
      rom_addr_ff <= '0;
      rom_rd_ff   <= 1'b0;
      jump_ff     <= 1'b0;
      busy_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      op_ff       <= nxt_op;
      to_acc_ff   <= nxt_to_acc;
      loc_ff      <= nxt_loc;
      null_ff     <= nxt_null;
      ram_addr_ff <= nxt_ram_addr;
      ram_rd_ff   <= nxt_ram_rd;
      rom_addr_ff <= nxt_rom_addr;
      rom_rd_ff   <= nxt_rom_rd;
      jump_ff     <= nxt_jump;
      busy_ff     <= nxt_busy;
    end
  end

  // register contents and flags
  always_comb begin
    nxt_pointer_a          = pointer_a_ff;
    nxt_pointer_b          = pointer_b_ff;
    nxt_tblp               = tblp_ff;
    nxt_tbhp               = tbhp_ff;
    nxt_lookup_result_high = lookup_result_high_ff;
    nxt_acc                = working_reg_ff;
    nxt_status             = status_ff;
    nxt_pc                 = pc_ff;
    wr_go                  = 1'b0;
    wr_data                = csr_pkg::NULL_BYTE;
    wr_pcl                 = 1'b0;
    if (state_ff == csr_pkg::S_EXEC) begin
      if (op_ff == csr_pkg::OP_LOAD) begin
        nxt_acc = opnd;
      end else if (op_ff == csr_pkg::OP_STORE) begin
        wr_go   = 1'b1;
        wr_data = working_reg_ff;
      end else begin
        if (to_acc_ff) begin
          nxt_acc = alu_res;
        end else begin
          wr_go   = 1'b1;
          wr_data = alu_res;
        end
        if (upd_c) begin
          nxt_status[csr_pkg::ST_C] = alu_c;
        end
        if (upd_acov) begin
          nxt_status[csr_pkg::ST_AC] = alu_ac;
          nxt_status[csr_pkg::ST_OV] = alu_ov;
        end
        if (upd_z) begin
          nxt_status[csr_pkg::ST_Z] = (alu_res == 8'h00);
        end
      end
    end else if (state_ff == csr_pkg::S_TABLE) begin
      nxt_lookup_result_high = rom_data[15:8];
      wr_go   = 1'b1;
      wr_data = rom_data[7:0];
    end
    // write back to a local register; ports store nothing
    if (wr_go && loc_ff && !null_ff) begin
      unique case (ram_addr_ff[7:0])
        csr_pkg::A_PTR_A: nxt_pointer_a = wr_data;
        csr_pkg::A_PTR_B: nxt_pointer_b = wr_data;
        csr_pkg::A_ACC:   nxt_acc       = wr_data;
        csr_pkg::A_PCL: begin
          wr_pcl = 1'b1;
        end
        csr_pkg::A_TBLP:  nxt_tblp      = wr_data;
        csr_pkg::A_TBHP:  nxt_tbhp      = wr_data;
        csr_pkg::A_STAT:  nxt_status[3:0] = wr_data[3:0];
        default: ;
      endcase
    end
    if (wr_pcl) begin
      nxt_pc = {pc_ff[csr_pkg::PC_W-1:8], wr_data};
    end else if (pc_step) begin
      nxt_pc = pc_ff + csr_pkg::PC_W'(1);
    end
    if (accept && op_code == csr_pkg::OP_CLRWDT) begin
      nxt_status[csr_pkg::ST_TO]  = 1'b0;
      nxt_status[csr_pkg::ST_PDF] = 1'b0;
    end
    if (accept && op_code == csr_pkg::OP_HALT) begin
      nxt_status[csr_pkg::ST_TO]  = 1'b0;
      nxt_status[csr_pkg::ST_PDF] = 1'b1;
    end
    if (wdt_timeout) begin
      nxt_status[csr_pkg::ST_TO] = 1'b1;
    end
    nxt_status[7:6] = 2'b00;
    nxt_ram_wr      = wr_go && !loc_ff;
    nxt_ram_wdata   = wr_data;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pointer_a_ff          <= csr_pkg::RST_BYTE;
      pointer_b_ff          <= csr_pkg::RST_BYTE;
      tblp_ff               <= csr_pkg::RST_BYTE;
      tbhp_ff               <= csr_pkg::RST_BYTE;
      lookup_result_high_ff <= csr_pkg::RST_BYTE;
      working_reg_ff        <= csr_pkg::RST_BYTE;
      status_ff             <= csr_pkg::RST_BYTE;
      pc_ff                 <= '0;
      ram_wr_ff             <= 1'b0;
      ram_wdata_ff          <= csr_pkg::RST_BYTE;
    end else begin
      pointer_a_ff          <= nxt_pointer_a;
      pointer_b_ff          <= nxt_pointer_b;
      tblp_ff               <= nxt_tblp;
      tbhp_ff               <= nxt_tbhp;
      lookup_result_high_ff <= nxt_lookup_result_high;
      working_reg_ff        <= nxt_acc;
      status_ff             <= nxt_status;
      pc_ff                 <= nxt_pc;
      ram_wr_ff             <= nxt_ram_wr;
      ram_wdata_ff          <= nxt_ram_wdata;
    end
  end

  sequence s_jump;
    jump_ff && busy_ff ##1 !busy_ff;
  endsequence

  property p_ptr_a_bank;
    @(posedge clk_sys) disable iff (!resetn)
    accept && op_addr == csr_pkg::A_IND_A |=>
      ram_addr_ff == {csr_pkg::BANK0, $past(pointer_a_ff)};
  endproperty
  a_ptr_a_bank: assert property (p_ptr_a_bank)
    else $error("pointer a access left bank 0");

  property p_ptr_b_bank;
    @(posedge clk_sys) disable iff (!resetn)
    accept && op_addr == csr_pkg::A_IND_B |=>
      ram_addr_ff[9:8] == $past(ptr_b_bank);
  endproperty
  a_ptr_b_bank: assert property (p_ptr_b_bank)
    else $error("pointer b bank not applied");

  property p_direct_bank0;
    @(posedge clk_sys) disable iff (!resetn)
    accept && op_addr != csr_pkg::A_IND_A &&
      op_addr != csr_pkg::A_IND_B |=> ram_addr_ff[9:8] == 2'b00;
  endproperty
  a_direct_bank0: assert property (p_direct_bank0)
    else $error("direct access outside bank 0");

  property p_pcl_jump;
    @(posedge clk_sys) disable iff (!resetn)
    wr_pcl |=> pc_ff[csr_pkg::PC_W-1:8] ==
      $past(pc_ff[csr_pkg::PC_W-1:8]) ##0 s_jump;
  endproperty
  a_pcl_jump: assert property (p_pcl_jump)
    else $error("pc low write jump wrong");

  property p_table_two;
    @(posedge clk_sys) disable iff (!resetn)
    accept && op_code == csr_pkg::OP_TABRD |=>
      rom_rd_ff && busy_ff ##1 (!busy_ff || jump_ff);
  endproperty
  a_table_two: assert property (p_table_two)
    else $error("table read not two cycles");

  property p_status_write;
    @(posedge clk_sys) disable iff (!resetn)
    wr_pcl == 1'b0 && wr_go && loc_ff && !null_ff &&
      ram_addr_ff[7:0] == csr_pkg::A_STAT && !wdt_timeout && !accept
      |=> status_ff[5:4] == $past(status_ff[5:4]);
  endproperty
  a_status_write: assert property (p_status_write)
    else $error("status write altered system flags");

  property p_halt_flags;
    @(posedge clk_sys) disable iff (!resetn)
    accept && op_code == csr_pkg::OP_HALT && !wdt_timeout |=>
      status_ff[csr_pkg::ST_PDF] && !status_ff[csr_pkg::ST_TO];
  endproperty
  a_halt_flags: assert property (p_halt_flags)
    else $error("halt flags wrong");

  property p_timeout_set;
    @(posedge clk_sys) disable iff (!resetn)
    wdt_timeout |=> status_ff[csr_pkg::ST_TO];
  endproperty
  a_timeout_set: assert property (p_timeout_set)
    else $error("timeout flag not set");

  property p_zero_acc;
    @(posedge clk_sys) disable iff (!resetn)
    state_ff == csr_pkg::S_EXEC && to_acc_ff && upd_z &&
      op_ff != csr_pkg::OP_LOAD && op_ff != csr_pkg::OP_STORE |=>
      status_ff[csr_pkg::ST_Z] == (working_reg_ff == 8'h00);
  endproperty
  a_zero_acc: assert property (p_zero_acc)
    else $error("zero flag disagrees with accumulator");

endmodule : csr_core_regs

// [csr_pkg.sv]
/*
  Shared constants and types of the core special register block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package csr_pkg;

  // bank 0 addresses of the registers held by this block
  localparam logic [7:0] A_IND_A   = 8'h00;
  localparam logic [7:0] A_PTR_A   = 8'h01;
  localparam logic [7:0] A_IND_B   = 8'h02;
  localparam logic [7:0] A_PTR_B   = 8'h03;
  localparam logic [7:0] A_ACC     = 8'h05;
  localparam logic [7:0] A_PCL     = 8'h06;
  localparam logic [7:0] A_TBLP    = 8'h07;
  localparam logic [7:0] A_LOOKUP_RESULT_HIGH    = 8'h08;
  localparam logic [7:0] A_TBHP    = 8'h09;
  localparam logic [7:0] A_STAT    = 8'h0a;
  localparam logic [7:0] A_LOC_TOP = 8'h0f;

  localparam int PC_W = 12;
  localparam int DM_W = 10;

  // status layout
  localparam int ST_C   = 0;
  localparam int ST_AC  = 1;
  localparam int ST_Z   = 2;
  localparam int ST_OV  = 3;
  localparam int ST_PDF = 4;
  localparam int ST_TO  = 5;

  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] NULL_BYTE = 8'h00;
  localparam logic [1:0] BANK0     = 2'h0;

  typedef enum logic [3:0] {
    OP_NOP, OP_LOAD, OP_STORE, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
    OP_INC, OP_DEC, OP_RLC, OP_RRC, OP_CLR, OP_TABRD, OP_CLRWDT, OP_HALT
  } csr_op_t;

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_TABLE, S_DUMMY} csr_state_t;

  // ops that fetch an operand and write back a result
  function automatic logic is_alu(input csr_op_t op);
    is_alu = (op >= OP_ADD) && (op <= OP_CLR);
  endfunction : is_alu

endpackage : csr_pkg

// [csr_addr_res.sv]
/*
  Operand address resolver: turns a direct address into the effective
  data memory address, following the pointers for the indirect ports.
  Assumes the pointer values are stable during the accepting cycle.
*/
`timescale 1ns/100ps
module csr_addr_res (
  input  wire logic [7:0]             op_addr,
  input  wire logic [7:0]             ptr_a,
  input  wire logic [7:0]             ptr_b,
  input  wire logic [1:0]             ptr_b_bank,
  output logic [csr_pkg::DM_W-1:0]    eff_addr,
  output logic                        is_local,
  output logic                        is_null
);
  logic [7:0] lo;
  logic [1:0] bank;

  always_comb begin
    lo   = op_addr;
    bank = csr_pkg::BANK0;
    if (op_addr == csr_pkg::A_IND_A) begin
      lo = ptr_a;
    end else if (op_addr == csr_pkg::A_IND_B) begin
      lo   = ptr_b;
      bank = ptr_b_bank;
    end
    eff_addr = {bank, lo};
    is_local = (bank == csr_pkg::BANK0) && (lo <= csr_pkg::A_LOC_TOP);
    // ports and unused slots have no storage
    is_null  = is_local && !(lo == csr_pkg::A_PTR_A ||
               lo == csr_pkg::A_PTR_B || (lo >= csr_pkg::A_ACC &&
               lo <= csr_pkg::A_STAT));
  end

endmodule : csr_addr_res

// [csr_alu.sv]
/*
  Arithmetic unit with flag generation for the accumulator core.
  Assumes acc is the first operand and opnd the memory operand.
*/
`timescale 1ns/100ps
module csr_alu (
  input  wire csr_pkg::csr_op_t op,
  input  wire logic [7:0]       acc,
  input  wire logic [7:0]       opnd,
  input  wire logic             c_in,
  output logic [7:0]            res,
  output logic                  c_out,
  output logic                  ac_out,
  output logic                  ov_out,
  output logic                  upd_c,
  output logic                  upd_acov,
  output logic                  upd_z
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] b;
  logic       cin0;

  always_comb begin
    b    = (op == csr_pkg::OP_SUB) ? ~opnd : opnd;
    cin0 = (op == csr_pkg::OP_SUB);
    sum  = {1'b0, acc} + {1'b0, b} + {8'h00, cin0};
    nib  = {1'b0, acc[3:0]} + {1'b0, b[3:0]} + {4'h0, cin0};
    res      = sum[7:0];
    c_out    = sum[8];
    ac_out   = nib[4];
    ov_out   = (acc[7] ^ b[7] ^ sum[7]) ^ sum[8];
    upd_c    = 1'b0;
    upd_acov = 1'b0;
    upd_z    = 1'b1;
    unique case (op)
      csr_pkg::OP_ADD, csr_pkg::OP_SUB: begin
        upd_c    = 1'b1;
        upd_acov = 1'b1;
      end
      csr_pkg::OP_AND: res = acc & opnd;
      csr_pkg::OP_OR:  res = acc | opnd;
      csr_pkg::OP_XOR: res = acc ^ opnd;
      csr_pkg::OP_INC: res = opnd + 8'h01;
      csr_pkg::OP_DEC: res = opnd - 8'h01;
      csr_pkg::OP_RLC: begin
        {c_out, res} = {opnd, c_in};
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      csr_pkg::OP_RRC: begin
        {res, c_out} = {c_in, opnd};
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      csr_pkg::OP_CLR: begin
        res   = csr_pkg::NULL_BYTE;
        upd_z = 1'b0;
      end
      default: upd_z = 1'b0;
    endcase
  end

endmodule : csr_alu

// [csr_mem_model.sv]
/*
  Data and program memory model facing the core register block.
  Assumes writes land on the rising edge and reads are asynchronous.
*/
`timescale 1ns/100ps
module csr_mem_model (
  input  wire logic        clk_sys,
  input  wire logic [9:0]  ram_addr_ff,
  input  wire logic        ram_rd_ff,
  input  wire logic        ram_wr_ff,
  input  wire logic [7:0]  ram_wdata_ff,
  input  wire logic [11:0] rom_addr_ff,
  input  wire logic        rom_rd_ff,
  output logic [7:0]       ram_rdata,
  output logic [15:0]      rom_data
);
  logic [7:0]  mem [1024];
  logic [15:0] word;

  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 8'h00;
    end
  end

  always @(posedge clk_sys) begin
    if (ram_wr_ff) begin
      mem[ram_addr_ff] <= ram_wdata_ff;
    end
  end

  // idle buses show inverted data, never a stale copy
  always_comb begin
    word = {rom_addr_ff[7:0] ^ 8'h3c, ~rom_addr_ff[7:0]};
    ram_rdata = ram_rd_ff ? mem[ram_addr_ff] : ~mem[ram_addr_ff];
    rom_data = rom_rd_ff ? word : ~word;
  end
endmodule : csr_mem_model

// [core_special_registers_tb.sv]
/*
  Self-checking bench of the core special registers.
  Assumes csr_mem_model answers data and table reads.
*/
`timescale 1ns/100ps
module core_special_registers_tb;
  logic             clk_sys;
  logic             resetn;
  logic             op_valid;
  csr_pkg::csr_op_t op_code;
  logic [7:0]       op_addr;
  logic             op_to_acc;
  logic [1:0]       ptr_b_bank;
  logic             pc_step;
  logic             wdt_timeout;
  logic [7:0]       ram_rdata;
  logic [15:0]      rom_data;
  logic             busy_ff;
  logic [9:0]       ram_addr_ff;
  logic             ram_rd_ff;
  logic             ram_wr_ff;
  logic [7:0]       ram_wdata_ff;
  logic [11:0]      rom_addr_ff;
  logic             rom_rd_ff;
  logic [11:0]      pc_ff;
  logic             jump_ff;
  logic [7:0]       working_reg_ff;
  logic [7:0]       status_ff;
  int               n_errors;
  int               n_tests;
  int               nb;
  int               njmp;

  csr_core_regs dut (
    .clk_sys, .resetn, .op_valid, .op_code, .op_addr, .op_to_acc,
    .ptr_b_bank, .pc_step, .wdt_timeout, .ram_rdata, .rom_data,
    .busy_ff, .ram_addr_ff, .ram_rd_ff, .ram_wr_ff, .ram_wdata_ff,
    .rom_addr_ff, .rom_rd_ff, .pc_ff, .jump_ff, .working_reg_ff,
    .status_ff
  );

  csr_mem_model mdl (
    .clk_sys, .ram_addr_ff, .ram_rd_ff, .ram_wr_ff, .ram_wdata_ff,
    .rom_addr_ff, .rom_rd_ff, .ram_rdata, .rom_data
  );

  always #50 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (jump_ff === 1'b1) begin
      njmp++;
    end
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  // one instruction; nb counts its busy cycles
  task automatic run(input csr_pkg::csr_op_t c, input logic [7:0] a,
                     input logic t);
    op_code = c;
    op_addr = a;
    op_to_acc = t;
    op_valid = 1'b1;
    tick();
    op_valid = 1'b0;
    for (nb = 0; nb < 8 && busy_ff === 1'b1; nb++) begin
      tick();
    end
    if (nb == 8) begin
      n_errors++;
      results();
    end
    tick();
  endtask : run

  task automatic st(input logic [7:0] a);
    run(csr_pkg::OP_STORE, a, 1'b0);
  endtask : st

  task automatic setacc(input logic [7:0] v);
    mdl.mem[10'h020] = v;
    run(csr_pkg::OP_LOAD, 8'h20, 1'b1);
  endtask : setacc

  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    run(csr_pkg::OP_LOAD, a, 1'b1);
    chk(working_reg_ff, v);
  endtask : rd

  task automatic dog();
    wdt_timeout = 1'b1;
    tick();
    wdt_timeout = 1'b0;
    tick();
  endtask : dog

  // {result, ov, z, ac, c}
  function automatic logic [11:0] alu(input logic [7:0] a,
                                      input logic [7:0] b, input logic s);
    logic [7:0] m;
    logic [8:0] r;
    logic       h;
    logic       c7;
    m = s ? ~b : b;
    r = a + m + s;
    h = (a[3:0] + m[3:0] + s) > 5'd15;
    c7 = (a[6:0] + m[6:0] + s) > 8'd127;
    alu = {r[7:0], c7 ^ r[8], r[7:0] == 8'h00, h, r[8]};
  endfunction : alu

  initial begin
    logic [16:0] tv [8];
    logic [11:0] e;
    tv = '{17'h07f01, 17'h00f01, 17'h08080, 17'h10503,
           17'h10305, 17'h11001, 17'h18001, 17'h0ff01};
    clk_sys = 1'b0;
    resetn = 1'b0;
    op_valid = 1'b0;
    op_code = csr_pkg::OP_NOP;
    op_addr = 8'h00;
    op_to_acc = 1'b0;
    ptr_b_bank = 2'h2;
    pc_step = 1'b0;
    wdt_timeout = 1'b0;
    n_errors = 0;
    n_tests = 0;
    njmp = 0;
    repeat (5) tick();
    resetn = 1'b1;
    tick();
    chk(status_ff, 16'h0000);
    chk(pc_ff, 16'h0000);
    run(csr_pkg::OP_HALT, 8'h00, 1'b0);
    chk(status_ff, 16'h0010);
    dog();
    chk(status_ff, 16'h0030);
    setacc(8'hff);
    st(csr_pkg::A_STAT);
    chk(status_ff, 16'h003f);
    setacc(8'h00);
    st(csr_pkg::A_STAT);
    chk(status_ff, 16'h0030);
    run(csr_pkg::OP_CLRWDT, 8'h00, 1'b0);
    chk(status_ff, 16'h0000);
    dog();
    run(csr_pkg::OP_HALT, 8'h00, 1'b0);
    chk(status_ff, 16'h0010);
    // timeout in the clearing cycle: the set wins
    op_code = csr_pkg::OP_CLRWDT;
    op_valid = 1'b1;
    wdt_timeout = 1'b1;
    tick();
    op_valid = 1'b0;
    wdt_timeout = 1'b0;
    chk(status_ff, 16'h0020);
    tick();
    run(csr_pkg::OP_CLRWDT, 8'h00, 1'b0);
    chk(status_ff, 16'h0000);
    $display("flags test done");
    setacc(8'h85);
    chk(ram_addr_ff, 16'h0020);
    st(csr_pkg::A_PTR_A);
    st(csr_pkg::A_PTR_B);
    setacc(8'h00);
    rd(csr_pkg::A_PTR_A, 8'h85);
    mdl.mem[10'h085] = 8'h3c;
    mdl.mem[10'h285] = 8'h5a;
    rd(csr_pkg::A_IND_A, 8'h3c);
    chk(ram_addr_ff, 16'h0085);
    rd(csr_pkg::A_IND_B, 8'h5a);
    chk(ram_addr_ff, 16'h0285);
    run(csr_pkg::OP_INC, csr_pkg::A_PTR_A, 1'b0);
    mdl.mem[10'h086] = 8'hc3;
    rd(csr_pkg::A_IND_A, 8'hc3);
    setacc(8'h77);
    st(csr_pkg::A_IND_B);
    chk(mdl.mem[10'h285], 8'h77);
    setacc(8'h02);
    st(csr_pkg::A_PTR_A);
    rd(csr_pkg::A_IND_A, 8'h00);
    $display("pointer test done");
    for (int i = 0; i < 8; i++) begin
      setacc(tv[i][15:8]);
      mdl.mem[10'h021] = tv[i][7:0];
      run(tv[i][16] ? csr_pkg::OP_SUB : csr_pkg::OP_ADD, 8'h21, 1'b1);
      e = alu(tv[i][15:8], tv[i][7:0], tv[i][16]);
      chk(working_reg_ff, e[11:4]);
      chk(status_ff, {4'h0, e[3:0]});
    end
    setacc(8'h05);
    mdl.mem[10'h022] = 8'h40;
    run(csr_pkg::OP_OR, 8'h22, 1'b0);
    chk(status_ff, 16'h0003);
    chk(working_reg_ff, 16'h0005);
    chk(mdl.mem[10'h022], 8'h45);
    mdl.mem[10'h023] = 8'h02;
    run(csr_pkg::OP_RRC, 8'h23, 1'b0);
    chk(status_ff, 16'h0002);
    run(csr_pkg::OP_RLC, 8'h23, 1'b0);
    chk(status_ff, 16'h0003);
    setacc(8'h3c);
    mdl.mem[10'h025] = 8'h0f;
    run(csr_pkg::OP_AND, 8'h25, 1'b1);
    chk(working_reg_ff, 16'h000c);
    run(csr_pkg::OP_CLR, 8'h25, 1'b0);
    chk(mdl.mem[10'h025], 8'h00);
    chk(status_ff, 16'h0003);
    run(csr_pkg::OP_XOR, csr_pkg::A_ACC, 1'b1);
    chk(working_reg_ff, 16'h0000);
    chk(status_ff, 16'h0007);
    run(csr_pkg::OP_NOP, 8'h00, 1'b0);
    chk(status_ff, 16'h0007);
    $display("alu test done");
    pc_step = 1'b1;
    repeat (773) tick();
    pc_step = 1'b0;
    chk(pc_ff, 16'h0305);
    setacc(8'h4a);
    st(8'h24);
    chk(nb, 1);
    njmp = 0;
    st(csr_pkg::A_PCL);
    chk(pc_ff, 16'h034a);
    chk(nb, 2);
    chk(njmp, 1);
    $display("jump test done");
    setacc(8'h06);
    st(csr_pkg::A_TBLP);
    setacc(8'h07);
    st(csr_pkg::A_TBHP);
    run(csr_pkg::OP_TABRD, 8'h30, 1'b0);
    chk(nb, 1);
    chk(rom_addr_ff, 16'h0706);
    chk(mdl.mem[10'h030], 8'hf9);
    rd(csr_pkg::A_LOOKUP_RESULT_HIGH, 8'h3a);
    run(csr_pkg::OP_DEC, csr_pkg::A_TBLP, 1'b0);
    run(csr_pkg::OP_TABRD, 8'h31, 1'b0);
    chk(mdl.mem[10'h031], 8'hfa);
    st(csr_pkg::A_LOOKUP_RESULT_HIGH);
    rd(csr_pkg::A_LOOKUP_RESULT_HIGH, 8'h39);
    $display("table test done");
    setacc(8'h99);
    st(8'h0b);
    rd(8'h04, 8'h00);
    for (int i = 11; i < 16; i++) begin
      rd(8'(i), 8'h00);
    end
    $display("unused test done");
    resetn = 1'b0;
    tick();
    chk(pc_ff, 16'h0000);
    resetn = 1'b1;
    tick();
    chk(pc_ff, 16'h0000);
    chk(status_ff, 16'h0000);
    chk(busy_ff, 16'h0000);
    $display("reset test done");
    results();
  end
endmodule : core_special_registers_tb
